// file: rtl/packet_client_csr_bank.sv
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`include "pkt_client_consts.svh"

module packet_client_csr_bank
  import pkt_client_pkg::*;
#(
  parameter logic [31:0] IDENT_STRING = `IDENT_DEFAULT // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire reg_req_s bus_req,
  output logic [31:0] rd_data,
  input wire core_status_s core_status,
  input wire logic fifo_underflow,
  input wire logic fifo_overflow,
  output logic gen_disable,
  output logic loopback_reset,
  output logic irq
);

  core_status_s stat_meta_reg;
  core_status_s stat_sync_reg;
  logic [31:0] scratch_reg;
  logic [2:0] tx_store_reg;
  logic under_reg;
  logic over_reg;
  logic fifo_clr_reg;
  logic loop_rst_reg;
  irq_bits_t irq_status_reg;
  irq_bits_t irq_status_next;
  irq_bits_t irq_mask_reg;
  irq_bits_t irq_events;
  logic irq_reg;
  logic [31:0] rd_data_reg;
  logic [31:0] read_value;
  logic hit_scratch;
  logic hit_ident;
  logic hit_feature;
  logic hit_temp;
  logic hit_tx_ctrl;
  logic hit_fifo_err;
  logic hit_loop_rst;
  logic hit_irq_status;
  logic hit_irq_mask;
  logic hit_none;

  // Core status is asynchronous to sys_clk; two stages before any use
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stat_meta_reg <= '0;
      stat_sync_reg <= '0;
    end else begin
      stat_meta_reg <= core_status;
      stat_sync_reg <= stat_meta_reg;
    end
  end

  // Address decode, one hit per mapped word
  always_comb begin
    hit_scratch = 1'b0;
    hit_ident = 1'b0;
    hit_feature = 1'b0;
    hit_temp = 1'b0;
    hit_tx_ctrl = 1'b0;
    hit_fifo_err = 1'b0;
    hit_loop_rst = 1'b0;
    hit_irq_status = 1'b0;
    hit_irq_mask = 1'b0;
    hit_none = 1'b0;
    if (bus_req.addr == `ADDR_SCRATCH) begin
      hit_scratch = 1'b1;
    end else if (bus_req.addr == `ADDR_IDENT) begin
      hit_ident = 1'b1;
    end else if (bus_req.addr == `ADDR_FEATURE) begin
      hit_feature = 1'b1;
    end else if (bus_req.addr == `ADDR_TEMP) begin
      hit_temp = 1'b1;
    end else if (bus_req.addr == `ADDR_TX_CTRL) begin
      hit_tx_ctrl = 1'b1;
    end else if (bus_req.addr == `ADDR_FIFO_ERR) begin
      hit_fifo_err = 1'b1;
    end else if (bus_req.addr == `ADDR_LOOP_RST) begin
      hit_loop_rst = 1'b1;
    end else if (bus_req.addr == `ADDR_IRQ_STATUS) begin
      hit_irq_status = 1'b1;
    end else if (bus_req.addr == `ADDR_IRQ_MASK) begin
      hit_irq_mask = 1'b1;
    end else begin
      hit_none = 1'b1; // Unmapped word
    end
  end

  // Scratch word, plain storage
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scratch_reg <= `SCRATCH_RESET;
    end else if (bus_req.wr && hit_scratch) begin
      scratch_reg <= bus_req.wdata;
    end
  end

  // Transmit control; reserved bits kept as storage so they read back
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_store_reg <= `TX_CTRL_STORE_RESET;
    end else if (bus_req.wr && hit_tx_ctrl) begin
      tx_store_reg <= bus_req.wdata[`TX_CTRL_STORE_MSB:`TX_CTRL_STORE_LSB];
    end
  end

  assign gen_disable = tx_store_reg[`TX_CTRL_DISABLE_BIT];

  // Clear bit is a level: flags stay zero for as long as it is held
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fifo_clr_reg <= `FLAG_RESET;
    end else if (bus_req.wr && hit_fifo_err) begin
      fifo_clr_reg <= bus_req.wdata[`FIFO_ERR_CLR_BIT];
    end
  end

  // Sticky loopback FIFO flags; held clear wins over a new event
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      under_reg <= `FLAG_RESET;
      over_reg <= `FLAG_RESET;
    end else if (fifo_clr_reg) begin
      under_reg <= `FLAG_RESET;
      over_reg <= `FLAG_RESET;
    end else begin
      under_reg <= under_reg | fifo_underflow;
      over_reg <= over_reg | fifo_overflow;
    end
  end

  // Loopback path reset, driven out as a level while software holds it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      loop_rst_reg <= `LOOP_RST_RESET;
    end else if (bus_req.wr && hit_loop_rst) begin
      loop_rst_reg <= bus_req.wdata[`LOOP_RST_BIT];
    end
  end

  assign loopback_reset = loop_rst_reg;

  // Interrupt status, write one to clear; a same-cycle event wins
  always_comb begin
    irq_events = '0;
    irq_events[`IRQ_UNDER_BIT] = fifo_underflow;
    irq_events[`IRQ_OVER_BIT] = fifo_overflow;
    irq_status_next = irq_status_reg;
    if (bus_req.wr && hit_irq_status) begin
      irq_status_next = irq_status_reg & ~bus_req.wdata[`IRQ_OVER_BIT:`IRQ_UNDER_BIT];
    end
    irq_status_next = irq_status_next | irq_events;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_status_reg <= `IRQ_RESET;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_mask_reg <= `IRQ_RESET;
    end else if (bus_req.wr && hit_irq_mask) begin
      irq_mask_reg <= bus_req.wdata[`IRQ_OVER_BIT:`IRQ_UNDER_BIT];
    end
  end

  // Registered output, so it trails the status bit by one cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  assign irq = irq_reg;

  // Read mux; unmapped words and bits above each word's fields read zero
  always_comb begin
    read_value = `RDATA_IDLE;
    if (hit_scratch) begin
      read_value = scratch_reg;
    end else if (hit_ident) begin
      read_value = IDENT_STRING;
    end else if (hit_feature) begin
      read_value = 32'(stat_sync_reg.feature);
    end else if (hit_temp) begin
      read_value = 32'(stat_sync_reg.temperature);
    end else if (hit_tx_ctrl) begin
      read_value = 32'({stat_sync_reg.loopback_mode, tx_store_reg});
    end else if (hit_fifo_err) begin
      read_value = 32'({fifo_clr_reg, over_reg, under_reg});
    end else if (hit_loop_rst) begin
      read_value = 32'(loop_rst_reg);
    end else if (hit_irq_status) begin
      read_value = 32'(irq_status_reg);
    end else if (hit_irq_mask) begin
      read_value = 32'(irq_mask_reg);
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_data_reg <= `RDATA_IDLE;
    end else if (bus_req.rd) begin
      rd_data_reg <= read_value;
    end else begin
      rd_data_reg <= `RDATA_IDLE;
    end
  end

  assign rd_data = rd_data_reg;

  // Checks on the register behaviour
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  scratch_write_a: assert property (
    bus_req.wr && hit_scratch |=> scratch_reg == $past(bus_req.wdata))
    else $error("scratch word did not take written value");

  ident_read_a: assert property (
    bus_req.rd && hit_ident |=> rd_data == IDENT_STRING)
    else $error("identification read mismatch");

  feature_read_a: assert property (
    bus_req.rd && hit_feature |=> rd_data == 32'($past(stat_sync_reg.feature)))
    else $error("feature vector read mismatch");

  temp_read_a: assert property (
    bus_req.rd && hit_temp |=> rd_data == 32'($past(stat_sync_reg.temperature)))
    else $error("temperature read mismatch");

  gen_disable_a: assert property (
    bus_req.wr && hit_tx_ctrl |=> gen_disable == $past(bus_req.wdata[`TX_CTRL_DISABLE_BIT]))
    else $error("generator disable does not follow write");

  loop_mode_a: assert property (
    bus_req.rd && hit_tx_ctrl |=> rd_data[3] == $past(stat_sync_reg.loopback_mode))
    else $error("loopback mode bit mismatch");

  under_sticky_a: assert property (
    (fifo_underflow || under_reg) && !fifo_clr_reg |=> under_reg)
    else $error("underflow flag not set or not sticky");

  over_sticky_a: assert property (
    (fifo_overflow || over_reg) && !fifo_clr_reg |=> over_reg)
    else $error("overflow flag not set or not sticky");

  clear_hold_a: assert property (
    fifo_clr_reg |=> !under_reg && !over_reg)
    else $error("flags not held clear while clear bit set");

  clear_write_a: assert property (
    bus_req.wr && hit_fifo_err && bus_req.wdata[`FIFO_ERR_CLR_BIT] |=> ##1 !under_reg && !over_reg)
    else $error("clear write did not clear flags");

  loop_reset_a: assert property (
    bus_req.wr && hit_loop_rst |=> loopback_reset == $past(bus_req.wdata[`LOOP_RST_BIT]))
    else $error("loopback reset does not follow write");

  irq_level_a: assert property (
    |(irq_status_reg & irq_mask_reg) |=> irq)
    else $error("unmasked status did not raise interrupt");

  read_idle_a: assert property (
    !bus_req.rd |=> rd_data == `RDATA_IDLE)
    else $error("read data not idle after non-read cycle");

  // Reset values, seen on the first edge out of reset
  tx_reset_a: assert property (
    $fell(reset) |-> tx_store_reg == `TX_CTRL_STORE_RESET && !gen_disable)
    else $error("transmit control not at reset value");

  err_reset_a: assert property (
    $fell(reset) |-> !under_reg && !over_reg && !fifo_clr_reg)
    else $error("loopback error word not cleared by reset");

  loop_rst_reset_a: assert property (
    $fell(reset) |-> !loopback_reset)
    else $error("loopback reset not low after reset");

  // Storage must not drift between writes
  scratch_hold_a: assert property (
    !(bus_req.wr && hit_scratch) |=> $stable(scratch_reg))
    else $error("scratch word changed without a write");

  tx_hold_a: assert property (
    !(bus_req.wr && hit_tx_ctrl) |=> $stable(tx_store_reg))
    else $error("transmit control changed without a write");

  loop_rst_hold_a: assert property (
    !(bus_req.wr && hit_loop_rst) |=> $stable(loopback_reset))
    else $error("loopback reset changed without a write");

  // Read path of the narrow words
  tx_read_a: assert property (
    bus_req.rd && hit_tx_ctrl |=> rd_data[`TX_CTRL_DISABLE_BIT] == $past(gen_disable))
    else $error("generator disable bit reads wrong");

  err_read_a: assert property (
    bus_req.rd && hit_fifo_err |=>
      rd_data[`FIFO_ERR_UNDER_BIT] == $past(under_reg) && rd_data[`FIFO_ERR_OVER_BIT] == $past(over_reg))
    else $error("loopback error flags read wrong");

  unmapped_read_a: assert property (
    bus_req.rd && hit_none |=> rd_data == `RDATA_IDLE)
    else $error("unmapped word did not read zero");

  // Sticky flags never set without their event; clear bit follows its write
  under_quiet_a: assert property (
    !under_reg && !fifo_underflow |=> !under_reg)
    else $error("underflow flag set with no event");

  over_quiet_a: assert property (
    !over_reg && !fifo_overflow |=> !over_reg)
    else $error("overflow flag set with no event");

  clear_level_a: assert property (
    bus_req.wr && hit_fifo_err |=> fifo_clr_reg == $past(bus_req.wdata[`FIFO_ERR_CLR_BIT]))
    else $error("clear bit does not follow write");

  // Interrupt status, mask and output level
  irq_under_set_a: assert property (
    fifo_underflow |=> irq_status_reg[`IRQ_UNDER_BIT])
    else $error("underflow event did not set status");

  irq_over_set_a: assert property (
    fifo_overflow |=> irq_status_reg[`IRQ_OVER_BIT])
    else $error("overflow event did not set status");

  irq_clear_a: assert property (
    bus_req.wr && hit_irq_status && bus_req.wdata[`IRQ_UNDER_BIT] && !fifo_underflow
      |=> !irq_status_reg[`IRQ_UNDER_BIT])
    else $error("status bit not cleared by writing one");

  irq_mask_a: assert property (
    bus_req.wr && hit_irq_mask |=> irq_mask_reg == $past(bus_req.wdata[`IRQ_OVER_BIT:`IRQ_UNDER_BIT]))
    else $error("interrupt mask does not follow write");

  irq_quiet_a: assert property (
    !(|(irq_status_reg & irq_mask_reg)) |=> !irq)
    else $error("interrupt high with nothing unmasked");

  // Main scenarios that the bench should reach
  underflow_seen_c: cover property (fifo_underflow && !fifo_clr_reg ##1 under_reg);
  clear_then_recapture_c: cover property (fifo_clr_reg ##1 !fifo_clr_reg ##[1:20] under_reg);
  gen_toggle_c: cover property (gen_disable ##[1:20] !gen_disable);
  irq_raised_c: cover property (!irq ##1 irq);
  irq_dropped_c: cover property (irq ##1 !irq);

endmodule

// file: include/pkt_client_consts.svh
`ifndef PKT_CLIENT_CONSTS_SVH
`define PKT_CLIENT_CONSTS_SVH

// Register word indices on the plain register port
`define ADDR_SCRATCH 16'h1000
`define ADDR_IDENT 16'h1001
`define ADDR_FEATURE 16'h1002
`define ADDR_TEMP 16'h1006
`define ADDR_TX_CTRL 16'h1010
`define ADDR_FIFO_ERR 16'h1015
`define ADDR_LOOP_RST 16'h1016
`define ADDR_IRQ_STATUS 16'h1020
`define ADDR_IRQ_MASK 16'h1021

// Transmit control fields; bit 3 is live loopback state, not stored
`define TX_CTRL_DISABLE_BIT 1
`define TX_CTRL_STORE_RESET 3'h5
`define TX_CTRL_STORE_MSB 2
`define TX_CTRL_STORE_LSB 0

// Loopback FIFO error fields
`define FIFO_ERR_UNDER_BIT 0
`define FIFO_ERR_OVER_BIT 1
`define FIFO_ERR_CLR_BIT 2

// Loopback path reset field
`define LOOP_RST_BIT 0

// Interrupt status and mask fields
`define IRQ_UNDER_BIT 0
`define IRQ_OVER_BIT 1

// Reset values
`define SCRATCH_RESET 32'h0
`define FLAG_RESET 1'h0
`define LOOP_RST_RESET 1'h0
`define IRQ_RESET 2'h0
`define RDATA_IDLE 32'h0

// Arbitrary neutral identification string
`define IDENT_DEFAULT 32'h504b434c

`endif

// file: include/pkt_client_pkg.sv
package pkt_client_pkg;

  // One register port request, all fields sampled on the same edge
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Status levels coming from the attached core, outside this clock
  typedef struct packed {
    logic [9:0] feature;
    logic [7:0] temperature;
    logic loopback_mode;
  } core_status_s;

  typedef logic [1:0] irq_bits_t;

endpackage

// file: bench/packet_client_csr_bank_tb.sv
`timescale 1ns/10ps
`include "pkt_client_consts.svh"

module packet_client_csr_bank_tb
  import pkt_client_pkg::*;
;
  localparam logic [31:0] IDENT_VALUE = 32'h51524d54; // Arbitrary value
  localparam int CYCLE_LIMIT = 5000;
  // Two feature patterns so that every bit is seen both ways
  localparam core_status_s PATS [2] = '{{10'h2a5, 8'ha5, 1'b1}, {10'h15a, 8'h5a, 1'b0}};

  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  reg_req_s bus_req = '0;
  core_status_s core_status = '0;
  logic fifo_underflow = 1'b0;
  logic fifo_overflow = 1'b0;
  logic [31:0] rd_data;
  logic gen_disable;
  logic loopback_reset;
  logic irq;
  int err_count = 0;
  int samples_checked = 0;
  int cycle_count = 0;

  packet_client_csr_bank #(.IDENT_STRING(IDENT_VALUE)) packet_client_csr_bank_i (
    .sys_clk(sys_clk),
    .reset(reset),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .core_status(core_status),
    .fifo_underflow(fifo_underflow),
    .fifo_overflow(fifo_overflow),
    .gen_disable(gen_disable),
    .loopback_reset(loopback_reset),
    .irq(irq)
  );

  always #5 sys_clk = ~sys_clk;

  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, well above the length of the sequence below
  always @(posedge sys_clk) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == CYCLE_LIMIT) begin
      err_count++;
      final_report;
    end
  end

  task chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task chk_bit(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  // One-cycle write strobe, released at the next edge
  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task rd_chk(input logic [15:0] a, input logic [31:0] exp, input string name);
    logic [31:0] d;
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rd_data;
    chk_word(name, exp, d);
  endtask

  task fifo_event(input logic under);
    @(posedge sys_clk);
    if (under) begin
      fifo_underflow <= 1'b1;
    end else begin
      fifo_overflow <= 1'b1;
    end
    @(posedge sys_clk);
    fifo_underflow <= 1'b0;
    fifo_overflow <= 1'b0;
  endtask

  task settle_irq(input logic exp);
    @(posedge sys_clk);
    #1;
    chk_bit("irq", exp, irq);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    chk_bit("gen_disable", 1'b0, gen_disable);
    chk_bit("loopback_reset", 1'b0, loopback_reset);
    rd_chk(`ADDR_TX_CTRL, 32'h5, "tx_ctrl");
    rd_chk(`ADDR_FIFO_ERR, 32'h0, "fifo_err");
    rd_chk(`ADDR_LOOP_RST, 32'h0, "loop_rst");
    rd_chk(`ADDR_IRQ_STATUS, 32'h0, "irq_status");
    rd_chk(`ADDR_IRQ_MASK, 32'h0, "irq_mask");
    // Read data must drop back to zero one cycle later
    @(posedge sys_clk);
    #1;
    chk_word("rd_idle", 32'h0, rd_data);
    // Scratch: successive writes one idle cycle apart, only the last one must survive
    wr(`ADDR_SCRATCH, 32'hffffffff);
    rd_chk(`ADDR_SCRATCH, 32'hffffffff, "scratch");
    wr(`ADDR_SCRATCH, 32'h00000000);
    wr(`ADDR_SCRATCH, 32'ha5c33c5a);
    rd_chk(`ADDR_SCRATCH, 32'ha5c33c5a, "scratch");
    // Read-only and unmapped words ignore writes
    wr(`ADDR_IDENT, 32'h0);
    rd_chk(`ADDR_IDENT, IDENT_VALUE, "ident");
    wr(16'h1003, 32'h1234abcd);
    rd_chk(16'h1003, 32'h0, "unmapped");
    rd_chk(16'h1011, 32'h0, "unmapped");
    // Status levels pass two sync stages before they show
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      core_status <= PATS[i];
      repeat (3) @(posedge sys_clk);
      wr(`ADDR_FEATURE, 32'h0);
      rd_chk(`ADDR_FEATURE, {22'h0, PATS[i].feature}, "feature");
      rd_chk(`ADDR_TEMP, {24'h0, PATS[i].temperature}, "temperature");
      rd_chk(`ADDR_TX_CTRL, {28'h0, PATS[i].loopback_mode, 3'h5}, "tx_ctrl");
    end
    // Generator disable; written bit 3 has no effect
    wr(`ADDR_TX_CTRL, 32'hf);
    rd_chk(`ADDR_TX_CTRL, 32'h7, "tx_ctrl");
    chk_bit("gen_disable", 1'b1, gen_disable);
    wr(`ADDR_TX_CTRL, 32'h5);
    settle_irq(1'b0);
    chk_bit("gen_disable", 1'b0, gen_disable);
    wr(`ADDR_LOOP_RST, 32'h1);
    rd_chk(`ADDR_LOOP_RST, 32'h1, "loop_rst");
    chk_bit("loopback_reset", 1'b1, loopback_reset);
    wr(`ADDR_LOOP_RST, 32'h0);
    rd_chk(`ADDR_LOOP_RST, 32'h0, "loop_rst");
    chk_bit("loopback_reset", 1'b0, loopback_reset);
    // Sticky flags, clear level, events lost while clearing
    fifo_event(1'b1);
    repeat (4) @(posedge sys_clk);
    rd_chk(`ADDR_FIFO_ERR, 32'h1, "fifo_err");
    fifo_event(1'b0);
    rd_chk(`ADDR_FIFO_ERR, 32'h3, "fifo_err");
    wr(`ADDR_FIFO_ERR, 32'h4);
    rd_chk(`ADDR_FIFO_ERR, 32'h4, "fifo_err");
    fifo_event(1'b0);
    rd_chk(`ADDR_FIFO_ERR, 32'h4, "fifo_err");
    wr(`ADDR_FIFO_ERR, 32'h0);
    rd_chk(`ADDR_FIFO_ERR, 32'h0, "fifo_err");
    fifo_event(1'b1);
    rd_chk(`ADDR_FIFO_ERR, 32'h1, "fifo_err");
    // Interrupt: status set even during clear, masked, then cleared
    rd_chk(`ADDR_IRQ_STATUS, 32'h3, "irq_status");
    chk_bit("irq", 1'b0, irq);
    wr(`ADDR_IRQ_MASK, 32'h2);
    settle_irq(1'b1);
    wr(`ADDR_IRQ_STATUS, 32'h2);
    rd_chk(`ADDR_IRQ_STATUS, 32'h1, "irq_status");
    chk_bit("irq", 1'b0, irq);
    fifo_event(1'b0);
    settle_irq(1'b1);
    wr(`ADDR_IRQ_STATUS, 32'h3);
    rd_chk(`ADDR_IRQ_STATUS, 32'h0, "irq_status");
    chk_bit("irq", 1'b0, irq);
    // Second reset in mid-run brings stored state back
    wr(`ADDR_TX_CTRL, 32'h2);
    wr(`ADDR_LOOP_RST, 32'h1);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    chk_bit("gen_disable", 1'b0, gen_disable);
    chk_bit("loopback_reset", 1'b0, loopback_reset);
    rd_chk(`ADDR_TX_CTRL, 32'h5, "tx_ctrl");
    rd_chk(`ADDR_FIFO_ERR, 32'h0, "fifo_err");
    final_report;
  end
endmodule
